//--- vic_map.vh
// Address map, field positions and fixed numbers of the interrupt controller
`ifndef VIC_MAP_VH
`define VIC_MAP_VH

`define VIC_MAX_LINES      496
`define VIC_VEC_W          512
`define VIC_EXC_OFFSET     9'h010
`define VIC_PRIO_W         8
`define VIC_PRIO_WORDS     124
`define VIC_PRIO_AW        7

`define VIC_ADDR_LINE_CNT  32'hE000E004
`define VIC_ADDR_SW_TRIG   32'hE000E3FC
`define VIC_ADDR_CLR_ACT   32'hE000E3F8
`define VIC_BASE_EN_SET    32'hE000E100
`define VIC_BASE_EN_CLR    32'hE000E180
`define VIC_BASE_PEND_SET  32'hE000E200
`define VIC_BASE_PEND_CLR  32'hE000E280
`define VIC_BASE_ACTIVE    32'hE000E300
`define VIC_BASE_PRIO      32'hE000E400

`define VIC_CLR_ACT_BIT    0
`define VIC_SW_TRIG_MSB    8
`define VIC_LINE_CNT_MSB   3

`endif

//--- vic_prio_mem.v
// Priority byte store with a bus port and a scan read port
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.vh"

module vic_prio_mem #(
    parameter DEPTH = `VIC_PRIO_WORDS,
    parameter AW    = `VIC_PRIO_AW
) (
    input  wire          clk_sys,
    input  wire          rst_n,
    input  wire [AW-1:0] a_addr,
    input  wire          a_we,
    input  wire [3:0]    a_be,
    input  wire [31:0]   a_wdata,
    output reg  [31:0]   a_rdata,
    input  wire [AW-1:0] b_addr,
    output reg  [31:0]   b_rdata
);
    reg [31:0] mem [0:DEPTH-1];
    integer    i;

    // Contents are cleared word by word on reset so priorities start at zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= 32'h0000_0000;
            end
        end else if (a_we && (a_addr < DEPTH)) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (a_be[i]) begin
                    mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            a_rdata <= 32'h0000_0000;
            b_rdata <= 32'h0000_0000;
        end else begin
            a_rdata <= (a_addr < DEPTH) ? mem[a_addr] : 32'h0000_0000;
            b_rdata <= (b_addr < DEPTH) ? mem[b_addr] : 32'h0000_0000;
        end
    end
endmodule // vic_prio_mem
`default_nettype wire

//--- vic_ctrl.v
// Vectored interrupt controller: line sampling, state bits, registers, winner scan
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.vh"

// What this block does
// - Configurable line count, at most 496
// - Read-only line count register at fixed address
// - Inputs work as level or pulse
// - Pulse during active sets pending too
// - Many pulses while active pend once
// - Level still high at return re-pends
// - Priority and fixed number choose the winner
// - Eight-bit priority, four per word
// - Enable set/clear, write one, read state
// - Disabled lines pend but never activate
// - Disable leaves active line active
// - Enables may be tied one per line
// - Pending set/clear, write one, read state
// - Pending clear leaves active untouched
// - Software set/clear per line is optional
// - Active bits readable beside pending bits
// - Software trigger number sets pending
// - Line number is exception number minus 16
// - Rising input between edges sets pending
// - Absent lines read zero, ignore writes
module vic_ctrl #(
    parameter             NUM_IRQ     = `VIC_MAX_LINES,
    parameter [511:0]     EN_TIED_ONE = {512{1'b0}},
    parameter [511:0]     SW_SET_OK   = {512{1'b1}},
    parameter [511:0]     SW_CLR_OK   = {512{1'b1}}
) (
    input  wire               clk_sys,
    input  wire               rst_n,
    input  wire [NUM_IRQ-1:0] irq_in,
    input  wire [31:0]        bus_addr,
    input  wire               bus_wr,
    input  wire               bus_rd,
    input  wire [3:0]         bus_be,
    input  wire [31:0]        bus_wdata,
    output reg  [31:0]        bus_rdata,
    output reg                bus_rvalid,
    output wire               irq_req,
    output reg  [8:0]         irq_excnum,
    output reg  [7:0]         irq_prio,
    input  wire               exc_enter,
    input  wire [8:0]         exc_enter_num,
    input  wire               exc_return,
    input  wire [8:0]         exc_return_num
);
    localparam VW = `VIC_VEC_W;
    localparam [511:0] IMPL = {512{1'b1}} >> (VW - NUM_IRQ);
    localparam integer LAST_WI = (NUM_IRQ + 3) / 4 - 1;
    localparam integer LINE_CNTI = (NUM_IRQ + 31) / 32 - 1;
    localparam [6:0] LAST_W = LAST_WI[6:0];
    localparam [3:0] LINE_CNT = LINE_CNTI[3:0];
    localparam [1:0] ST_SCAN = 2'b01;
    localparam [1:0] ST_DRAIN = 2'b10;

    reg  [VW-1:0] en_r;
    reg  [VW-1:0] en_nxt;
    reg  [VW-1:0] pend_r;
    reg  [VW-1:0] pend_nxt;
    reg  [VW-1:0] act_r;
    reg  [VW-1:0] act_nxt;
    reg  [VW-1:0] irq_q_r;
    wire [VW-1:0] irq_ext;
    wire [VW-1:0] en_eff;
    wire [VW-1:0] cand;

    function bank_hit;
        input [31:0] addr;
        input [31:0] base;
        begin
            bank_hit = (addr[31:6] == base[31:6]);
        end
    endfunction

    function [511:0] place_word;
        input [3:0]  idx;
        input [31:0] data;
        begin
            place_word = {480'h0, data} << {idx, 5'h00};
        end
    endfunction

    // Exception number to one-hot line vector, empty below the offset
    function [511:0] exc_onehot;
        input [8:0] num;
        begin
            if (num >= `VIC_EXC_OFFSET) begin
                exc_onehot = {511'h0, 1'b1} << (num - `VIC_EXC_OFFSET);
            end else begin
                exc_onehot = {512{1'b0}};
            end
        end
    endfunction

    // Thirty-two state bits that one bank register shows
    function [31:0] bank_word;
        input [511:0] vec;
        input [3:0]   idx;
        begin
            bank_word = vec[{idx, 5'h00} +: 32];
        end
    endfunction

    // Byte lane of a priority word belongs to a present line
    function line_here;
        input [6:0] w;
        input [1:0] ln;
        begin
            line_here = IMPL[{w, ln}];
        end
    endfunction

    assign irq_ext = {{(VW - NUM_IRQ){1'b0}}, irq_in};
    assign en_eff  = (en_r | EN_TIED_ONE) & IMPL;
    assign cand    = pend_r & en_eff & ~act_r;

    // Bus decode
    wire          hit_en_set   = bank_hit(bus_addr, `VIC_BASE_EN_SET);
    wire          hit_en_clr   = bank_hit(bus_addr, `VIC_BASE_EN_CLR);
    wire          hit_pend_set = bank_hit(bus_addr, `VIC_BASE_PEND_SET);
    wire          hit_pend_clr = bank_hit(bus_addr, `VIC_BASE_PEND_CLR);
    wire          hit_active   = bank_hit(bus_addr, `VIC_BASE_ACTIVE);
    wire          hit_prio     = (bus_addr[31:9] == `VIC_BASE_PRIO >> 9) &&
                                 (bus_addr[8:2] < `VIC_PRIO_WORDS);
    wire          hit_line_cnt = (bus_addr == `VIC_ADDR_LINE_CNT);
    wire          hit_sw_trig  = (bus_addr == `VIC_ADDR_SW_TRIG);
    wire          hit_clr_act  = (bus_addr == `VIC_ADDR_CLR_ACT);
    wire [3:0]    bank_idx     = bus_addr[5:2];
    wire [VW-1:0] wr_bits      = place_word(bank_idx, bus_wdata) & IMPL;

    wire [VW-1:0] en_set_w   = (bus_wr && hit_en_set)   ? wr_bits : {VW{1'b0}};
    wire [VW-1:0] en_clr_w   = (bus_wr && hit_en_clr)   ? wr_bits : {VW{1'b0}};
    wire [VW-1:0] pend_set_w = (bus_wr && hit_pend_set) ? wr_bits : {VW{1'b0}};
    wire [VW-1:0] pend_clr_w = (bus_wr && hit_pend_clr) ? wr_bits : {VW{1'b0}};
    wire          clr_all    = bus_wr && hit_clr_act && bus_wdata[`VIC_CLR_ACT_BIT];
    wire [VW-1:0] trig_w     = (bus_wr && hit_sw_trig) ?
                               ({511'h0, 1'b1} << bus_wdata[`VIC_SW_TRIG_MSB:0]) & IMPL :
                               {VW{1'b0}};
    wire [VW-1:0] enter_oh   = exc_enter  ? exc_onehot(exc_enter_num)  : {VW{1'b0}};
    wire [VW-1:0] return_oh  = exc_return ? exc_onehot(exc_return_num) : {VW{1'b0}};

    // Line sampling and state update, one loop over all lines
    reg samp_hi;
    reg assert_ev;
    reg deassert_ev;
    reg set_p;
    reg clr_p;
    integer n;
    always @* begin
        samp_hi     = 1'b0;
        assert_ev   = 1'b0;
        deassert_ev = 1'b0;
        set_p       = 1'b0;
        clr_p       = 1'b0;
        en_nxt      = ((en_r | en_set_w) & ~en_clr_w) & IMPL;
        act_nxt     = act_r;
        pend_nxt    = pend_r;
        for (n = 0; n < VW; n = n + 1) begin
            // Return or clear-all resamples the line as a level
            samp_hi     = clr_all | return_oh[n];
            assert_ev   = (irq_ext[n] & ~irq_q_r[n]) | (irq_ext[n] & samp_hi);
            // Software clear only takes when the line is low
            deassert_ev = ~irq_ext[n] & pend_clr_w[n] & SW_CLR_OK[n];
            set_p       = assert_ev | (pend_set_w[n] & SW_SET_OK[n]) | trig_w[n];
            clr_p       = (enter_oh[n] & en_eff[n]) | deassert_ev;
            // Set wins over clear; pending is one bit so pulses never count
            pend_nxt[n] = (set_p | (pend_r[n] & ~clr_p)) & IMPL[n];
            // Active leaves only by return or clear-all, never by disable
            act_nxt[n]  = ((act_r[n] & ~samp_hi) | (enter_oh[n] & en_eff[n])) & IMPL[n];
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            en_r    <= {VW{1'b0}};
            pend_r  <= {VW{1'b0}};
            act_r   <= {VW{1'b0}};
            irq_q_r <= {VW{1'b0}};
        end else begin
            en_r    <= en_nxt;
            pend_r  <= pend_nxt;
            act_r   <= act_nxt;
            irq_q_r <= irq_ext;
        end
    end

    // Priority store: bus port and scan port
    reg  [6:0]  scan_k_r;
    wire [31:0] prio_bus_q;
    wire [31:0] prio_scan_q;
    wire [6:0]  prio_waddr = bus_addr[8:2];
    reg  [3:0]  prio_be;
    // Own loop index per process; a shared one would retrigger the others
    integer     bm;
    always @* begin
        prio_be = 4'h0;
        for (bm = 0; bm < 4; bm = bm + 1) begin
            prio_be[bm] = bus_be[bm] & line_here(prio_waddr, bm[1:0]);
        end
    end

    vic_prio_mem #(
        .DEPTH (`VIC_PRIO_WORDS),
        .AW    (`VIC_PRIO_AW)
    ) u_prio (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .a_addr  (prio_waddr),
        .a_we    (bus_wr && hit_prio),
        .a_be    (prio_be),
        .a_wdata (bus_wdata),
        .a_rdata (prio_bus_q),
        .b_addr  (scan_k_r),
        .b_rdata (prio_scan_q)
    );

    // Read path, two cycles for every register so priority reads line up
    reg  [31:0] rd_s1_r;
    reg         rd_prio_r;
    reg  [6:0]  rd_pword_r;
    reg         rd_s1_v_r;
    reg  [31:0] rd_sel;
    reg  [31:0] prio_rmask;
    integer     br;
    always @* begin
        rd_sel = 32'h0000_0000;
        if (hit_en_set || hit_en_clr) begin
            rd_sel = bank_word(en_eff, bank_idx);
        end else if (hit_pend_set || hit_pend_clr) begin
            rd_sel = bank_word(pend_r, bank_idx);
        end else if (hit_active) begin
            rd_sel = bank_word(act_r, bank_idx);
        end else if (hit_line_cnt) begin
            rd_sel = {28'h0, LINE_CNT};
        end
        for (br = 0; br < 4; br = br + 1) begin
            prio_rmask[br*8 +: 8] = {8{line_here(rd_pword_r, br[1:0])}};
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_s1_r    <= 32'h0000_0000;
            rd_prio_r  <= 1'b0;
            rd_pword_r <= 7'h00;
            rd_s1_v_r  <= 1'b0;
            bus_rdata  <= 32'h0000_0000;
            bus_rvalid <= 1'b0;
        end else begin
            rd_s1_r    <= rd_sel;
            rd_prio_r  <= hit_prio;
            rd_pword_r <= prio_waddr;
            rd_s1_v_r  <= bus_rd;
            bus_rvalid <= rd_s1_v_r;
            if (rd_s1_v_r) begin
                bus_rdata <= rd_prio_r ? (prio_bus_q & prio_rmask) : rd_s1_r;
            end
        end
    end

    // Winner scan: one priority word per cycle, result republished each sweep
    reg  [1:0]  st_r;
    reg  [6:0]  scan_kd_r;
    reg         scan_vd_r;
    reg         best_v_r;
    reg  [8:0]  best_i_r;
    reg  [7:0]  best_p_r;
    reg         win_v_r;
    reg         best_v_nxt;
    reg  [8:0]  best_i_nxt;
    reg  [7:0]  best_p_nxt;
    reg  [8:0]  li;
    reg  [7:0]  lp;
    integer     bw;
    always @* begin
        best_v_nxt = best_v_r;
        best_i_nxt = best_i_r;
        best_p_nxt = best_p_r;
        li         = 9'h000;
        lp         = 8'h00;
        if (scan_vd_r) begin
            for (bw = 0; bw < 4; bw = bw + 1) begin
                li = {scan_kd_r, bw[1:0]};
                lp = prio_scan_q[bw*8 +: 8];
                // Strict compare: ascending scan keeps the lower number on a tie
                if (cand[li] && (!best_v_nxt || (lp < best_p_nxt))) begin
                    best_v_nxt = 1'b1;
                    best_i_nxt = li;
                    best_p_nxt = lp;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r       <= ST_SCAN;
            scan_k_r   <= 7'h00;
            scan_kd_r  <= 7'h00;
            scan_vd_r  <= 1'b0;
            best_v_r   <= 1'b0;
            best_i_r   <= 9'h000;
            best_p_r   <= 8'h00;
            win_v_r    <= 1'b0;
            irq_excnum <= 9'h000;
            irq_prio   <= 8'h00;
        end else begin
            scan_kd_r <= scan_k_r;
            best_v_r  <= best_v_nxt;
            best_i_r  <= best_i_nxt;
            best_p_r  <= best_p_nxt;
            case (st_r)
                ST_SCAN: begin
                    scan_vd_r <= 1'b1;
                    if (scan_k_r == LAST_W) begin
                        st_r <= ST_DRAIN;
                    end else begin
                        scan_k_r <= scan_k_r + 7'h01;
                    end
                end
                ST_DRAIN: begin
                    // Last word is being judged now; publish and restart
                    scan_vd_r  <= 1'b0;
                    scan_k_r   <= 7'h00;
                    win_v_r    <= best_v_nxt;
                    irq_excnum <= best_i_nxt + `VIC_EXC_OFFSET;
                    irq_prio   <= best_p_nxt;
                    best_v_r   <= 1'b0;
                    st_r       <= ST_SCAN;
                end
                default: begin
                    st_r     <= ST_SCAN;
                    scan_k_r <= 7'h00;
                end
            endcase
        end
    end

    // Published winner is a sweep old; drop it once it stops being a candidate
    assign irq_req = win_v_r && cand[irq_excnum - `VIC_EXC_OFFSET];
endmodule // vic_ctrl
`default_nettype wire

//--- vic_ctrl_sva.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.vh"
module vic_ctrl_sva #(
    parameter NUM_IRQ = `VIC_MAX_LINES
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [31:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic        bus_rvalid,
    input wire logic        irq_req,
    input wire logic [8:0]  irq_excnum,
    input wire logic        exc_enter,
    input wire logic [8:0]  exc_enter_num
);
    localparam [31:0] BANKS = (NUM_IRQ + 31) / 32;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_RD_LAT: assert property (bus_rd |-> ##2 bus_rvalid)
        else $error("read answer late or missing");
    AST_RD_CAUSE: assert property (bus_rvalid |-> $past(bus_rd, 2))
        else $error("read answer without request");
    AST_RD_HOLD: assert property (!bus_rvalid |-> $stable(bus_rdata))
        else $error("read data moved without answer");
    AST_LINE_CNT: assert property (bus_rd && bus_addr == `VIC_ADDR_LINE_CNT
        |-> ##2 bus_rdata == BANKS - 32'h1)
        else $error("line count register wrong");
    AST_RESERVED: assert property (bus_rd && bus_addr == 32'hE000E340
        |-> ##2 bus_rdata == 32'h0)
        else $error("reserved address not zero");
    AST_ABSENT_BANK: assert property (bus_rd && bus_addr == `VIC_BASE_PEND_SET + 4 * BANKS
        |-> ##2 bus_rdata == 32'h0)
        else $error("absent bank not zero");
    AST_EXC_RANGE: assert property (irq_req |-> irq_excnum >= 9'h010
        && irq_excnum < NUM_IRQ + 16)
        else $error("request number out of range");
    AST_REQ_DROP: assert property (exc_enter && irq_req && exc_enter_num == irq_excnum
        |-> ##[1:2] !irq_req)
        else $error("request stays after entry");
endmodule // vic_ctrl_sva
bind vic_ctrl vic_ctrl_sva #(.NUM_IRQ(NUM_IRQ)) u_vic_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .irq_req(irq_req), .irq_excnum(irq_excnum), .exc_enter(exc_enter),
    .exc_enter_num(exc_enter_num));
`default_nettype wire

//--- vic_core_model.sv
// Core model that takes the presented interrupt when allowed
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    input wire logic       clk_sys,
    input wire logic       accept,
    input wire logic       irq_req,
    input wire logic [8:0] irq_excnum,
    output var logic       exc_enter = 1'b0,
    output var logic [8:0] exc_enter_num = 9'h000
);
    // Guard on own pulse: request drops only after entry lands
    always @(negedge clk_sys) begin
        if (accept && irq_req && !exc_enter) begin
            exc_enter <= 1'b1;
            exc_enter_num <= irq_excnum;
        end else begin
            exc_enter <= 1'b0;
            exc_enter_num <= ~exc_enter_num;
        end
    end
endmodule // vic_core_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.vh"
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [39:0] irq_in = 40'h0;
    logic [31:0] bus_addr = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [3:0]  bus_be = 4'hF;
    logic [31:0] bus_wdata = 32'h0;
    logic [31:0] bus_rdata;
    logic        bus_rvalid;
    logic        irq_req;
    logic [8:0]  irq_excnum;
    logic [7:0]  irq_prio;
    logic        exc_enter;
    logic [8:0]  exc_enter_num;
    logic        exc_return = 1'b0;
    logic [8:0]  exc_return_num = 9'h000;
    logic        accept = 1'b0;
    int          errors = 0;
    int          checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    vic_ctrl #(.NUM_IRQ(40)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .irq_in(irq_in),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .irq_req(irq_req), .irq_excnum(irq_excnum), .irq_prio(irq_prio),
        .exc_enter(exc_enter), .exc_enter_num(exc_enter_num), .exc_return(exc_return),
        .exc_return_num(exc_return_num));
    vic_core_model core (.clk_sys(clk_sys), .accept(accept), .irq_req(irq_req),
        .irq_excnum(irq_excnum), .exc_enter(exc_enter), .exc_enter_num(exc_enter_num));
    task automatic complete_run;
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_be = be;
        bus_wr = 1'b1;
        @(negedge clk_sys);
        bus_wr = 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
        repeat (2) @(negedge clk_sys);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        @(negedge clk_sys);
        chk("rvalid", 32'h1, {31'h0, bus_rvalid});
        chk(nm, exp, bus_rdata);
    endtask
    task automatic pulse(input int k);
        @(negedge clk_sys);
        irq_in[k] = 1'b1;
        @(negedge clk_sys);
        irq_in[k] = 1'b0;
    endtask
    // Sweep lag bounds the wait: two sweeps of 11 plus slack
    task automatic enter(input logic [8:0] num);
        int i;
        for (i = 0; i < 40 && irq_req !== 1'b1; i++) @(negedge clk_sys);
        chk("req", 32'h1, {31'h0, irq_req});
        chk("excnum", {23'h0, num}, {23'h0, irq_excnum});
        accept = 1'b1;
        for (i = 0; i < 40 && exc_enter !== 1'b1; i++) @(posedge clk_sys);
        chk("enter_num", {23'h0, num}, {23'h0, exc_enter_num});
        @(negedge clk_sys);
        accept = 1'b0;
    endtask
    task automatic ret(input logic [8:0] num);
        @(negedge clk_sys);
        exc_return = 1'b1;
        exc_return_num = num;
        @(negedge clk_sys);
        exc_return = 1'b0;
        exc_return_num = ~num;
    endtask
    task automatic t_regs;
        rd(`VIC_ADDR_LINE_CNT, 32'h1, "line_cnt");
        rd(32'hE000E340, 32'h0, "reserved");
        wr(`VIC_BASE_EN_SET + 4, 32'hFFFFFFFF);
        rd(`VIC_BASE_EN_SET + 4, 32'h000000FF, "en_bank1");
        rd(`VIC_BASE_PEND_SET + 8, 32'h0, "pend_bank2");
        wr(`VIC_BASE_EN_CLR + 4, 32'hFFFFFFFF);
        rd(`VIC_BASE_EN_SET + 4, 32'h0, "en_bank1_clr");
    endtask
    task automatic t_enable;
        wr(`VIC_BASE_EN_SET, 32'h0000000F);
        wr(`VIC_BASE_EN_SET, 32'h0);
        rd(`VIC_BASE_EN_CLR, 32'h0000000F, "en_read");
        wr(`VIC_BASE_EN_CLR, 32'h00000005);
        rd(`VIC_BASE_EN_SET, 32'h0000000A, "en_clear");
        wr(`VIC_BASE_EN_CLR, 32'h0000000A);
    endtask
    task automatic t_disabled;
        pulse(3);
        rd(`VIC_BASE_PEND_SET, 32'h00000008, "pend_disabled");
        repeat (30) @(negedge clk_sys);
        chk("req_disabled", 32'h0, {31'h0, irq_req});
        wr(`VIC_BASE_PEND_CLR, 32'h00000008);
        rd(`VIC_BASE_PEND_CLR, 32'h0, "pend_clr");
    endtask
    task automatic t_priority;
        wr(`VIC_BASE_PRIO, 32'h00204000);
        wr(`VIC_BASE_PRIO, 32'hFFFFFFFF, 4'h8);
        rd(`VIC_BASE_PRIO, 32'hFF204000, "prio_word");
        wr(`VIC_BASE_EN_SET, 32'h00000006);
        wr(`VIC_BASE_PEND_SET, 32'h00000006);
        enter(9'h012);
        chk("prio", 32'h20, {24'h0, irq_prio});
        rd(`VIC_BASE_ACTIVE, 32'h00000004, "active");
        rd(`VIC_BASE_PEND_SET, 32'h00000002, "pend_after_entry");
        wr(`VIC_BASE_PEND_CLR, 32'h00000002);
    endtask
    task automatic t_active_pulse;
        pulse(2);
        pulse(2);
        rd(`VIC_BASE_PEND_SET, 32'h00000004, "pend_active");
        wr(`VIC_BASE_EN_CLR, 32'h00000004);
        rd(`VIC_BASE_ACTIVE, 32'h00000004, "active_disabled");
        wr(`VIC_BASE_PEND_CLR, 32'h00000004);
        rd(`VIC_BASE_PEND_SET, 32'h0, "pend_cleared");
        rd(`VIC_BASE_ACTIVE, 32'h00000004, "active_kept");
        ret(9'h012);
        rd(`VIC_BASE_ACTIVE, 32'h0, "active_ret");
    endtask
    task automatic t_level;
        wr(`VIC_BASE_EN_SET, 32'h00000020);
        @(negedge clk_sys);
        irq_in[5] = 1'b1;
        enter(9'h015);
        rd(`VIC_BASE_PEND_SET, 32'h0, "pend_entered");
        ret(9'h015);
        rd(`VIC_BASE_PEND_SET, 32'h00000020, "level_repend");
        wr(`VIC_BASE_PEND_CLR, 32'h00000020);
        rd(`VIC_BASE_PEND_SET, 32'h00000020, "clr_refused");
        enter(9'h015);
        wr(`VIC_ADDR_CLR_ACT, 32'h00000001);
        rd(`VIC_BASE_ACTIVE, 32'h0, "clear_all");
        rd(`VIC_BASE_PEND_SET, 32'h00000020, "clear_all_repend");
        @(negedge clk_sys);
        irq_in[5] = 1'b0;
        wr(`VIC_BASE_PEND_CLR, 32'h00000020);
        rd(`VIC_BASE_PEND_SET, 32'h0, "level_low_clr");
    endtask
    task automatic t_sw_trig;
        wr(`VIC_ADDR_SW_TRIG, 32'h00000007);
        rd(`VIC_BASE_PEND_SET, 32'h00000080, "sw_trig");
    endtask
    initial begin
        #50000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        t_regs;
        t_enable;
        t_disabled;
        t_priority;
        t_active_pulse;
        t_level;
        t_sw_trig;
        complete_run;
    end
endmodule // testbench
`default_nettype wire
